// ### rtl/reset_source_controller.sv
// Reset source controller: gathers reset requests, holds system reset, records the cause
`include "reset_source_consts.svh"

module reset_source_controller
  import reset_source_pkg::*;
#(
  parameter logic [15:0] CODE_LIMIT = 16'h1fff,
  parameter int          WD_LIMIT   = 255
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        extResetIn_n,
  output logic             extResetOut,
  output logic             extResetOe,
  input  wire logic        supplyAbove,
  output logic             supplyMonitorOn,
  input  wire logic        systemClockSample,
  input  wire logic        comparatorOut,
  input  wire logic        watchdogKick,
  input  codeAccess_t      codeAccess,
  output logic             sysReset_n,
  output logic             wdTick
);

  rstState_t   state;
  cause_t      cause;
  causeFlags_t flags;
  logic [3:0]  holdCnt;
  logic        supplySrcEn;
  logic        clkLossEn;
  logic        compEn;
  logic        wdEn;
  logic [3:0]  wdPre;
  logic [7:0]  wdCnt;
  logic [11:0] lossCnt;
  logic        lastClkSample;
  logic        reqValid;
  cause_t      reqCause;
  logic        busHit;
  logic        busWrite;
  logic [7:0]  regIdx;
  logic        swForce;
  logic [7:0]  next_rdata;
  logic        supplyReq;
  logic        clkLossReq;
  logic        compReq;
  logic        wdReq;
  logic        memReq;
  logic        pinReq;

  assign regIdx   = wb_adr_i[9:2];
  assign busHit   = wb_cyc_i && wb_stb_i;
  // A write takes effect at the edge where the master sees ack
  assign busWrite = busHit && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign swForce  = busWrite && regIdx == `RSC_IDX_CAUSE && wb_dat_i[`RSC_SWRST_BIT];

  // Request sources
  assign supplyReq  = supplyMonitorOn && supplySrcEn && !supplyAbove;
  assign clkLossReq = clkLossEn && lossCnt >= 12'(`RSC_CLKLOSS_CYCLES);
  assign compReq    = compEn && !comparatorOut;
  assign wdReq      = wdEn && wdCnt >= 8'(WD_LIMIT);
  assign memReq     = codeAccess.valid && codeAccess.addr > CODE_LIMIT;
  assign pinReq     = !extResetIn_n && !extResetOe;

  // Priority merge into one request
  always_comb
  begin
    reqValid = 1'b1;
    reqCause = C_SUPPLY;
    if (supplyReq)
      reqCause = C_SUPPLY;
    else if (pinReq)
      reqCause = C_PIN;
    else if (clkLossReq)
      reqCause = C_CLKLOSS;
    else if (compReq)
      reqCause = C_COMP;
    else if (wdReq)
      reqCause = C_WDOG;
    else if (memReq)
      reqCause = C_MEM;
    else if (swForce)
      reqCause = C_SW;
    else
      reqValid = 1'b0;
  end

  // Reset sequencer; held while a level cause persists
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= ST_HOLD;
      cause   <= C_POR;
      holdCnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (reqValid)
          begin
            state   <= ST_HOLD;
            cause   <= reqCause;
            holdCnt <= 4'h0;
          end
        end
        ST_HOLD:
        begin
          if (supplyReq || pinReq || compReq)
            holdCnt <= 4'h0;
          else if (holdCnt == 4'(`RSC_HOLD_CYCLES - 1))
            state <= ST_RUN;
          else
            holdCnt <= holdCnt + 4'h1;
        end
        default:
          state <= ST_HOLD;
      endcase
    end
  end

  assign sysReset_n = (state == ST_RUN);
  assign extResetOut = 1'b0;
  // Only power-on and supply resets pull the pin low
  assign extResetOe = (state == ST_HOLD) && (cause == C_POR || cause == C_SUPPLY);

  // Cause flags written once on leaving reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      flags <= '0;
    else if (state == ST_HOLD && next_exit())
    begin
      flags         <= '0;
      flags.por     <= (cause == C_POR || cause == C_SUPPLY);
      flags.pin     <= (cause == C_PIN);
      flags.clkLoss <= (cause == C_CLKLOSS);
      flags.comp    <= (cause == C_COMP);
      flags.wdog    <= (cause == C_WDOG);
      flags.memory_error_flag  <= (cause == C_MEM);
      flags.sw      <= (cause == C_SW);
    end
  end

  function automatic logic next_exit();
    next_exit = !(supplyReq || pinReq || compReq)
                && holdCnt == 4'(`RSC_HOLD_CYCLES - 1);
  endfunction

  // Supply monitor enable survives all but power-on
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      supplyMonitorOn <= 1'b1;
    else if (busWrite && regIdx == `RSC_IDX_SUPPLY_CTL)
      supplyMonitorOn <= wb_dat_i[`RSC_SM_ENABLE_BIT];
  end

  // Source enables; comparator and clock loss cleared by any reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      supplySrcEn <= 1'b1;
      clkLossEn   <= 1'b0;
      compEn      <= 1'b0;
    end
    else if (state == ST_HOLD)
    begin
      clkLossEn <= 1'b0;
      compEn    <= 1'b0;
    end
    else if (busWrite && regIdx == `RSC_IDX_CAUSE)
    begin
      supplySrcEn <= wb_dat_i[`RSC_POR_BIT];
      clkLossEn   <= wb_dat_i[`RSC_CLKLOSS_BIT];
      compEn      <= wb_dat_i[`RSC_COMP_BIT];
    end
  end

  // Clock loss one-shot: retriggered by each edge of the sampled clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastClkSample <= 1'b0;
      lossCnt       <= 12'h000;
    end
    else
    begin
      lastClkSample <= systemClockSample;
      if (state == ST_HOLD || systemClockSample != lastClkSample)
        lossCnt <= 12'h000;
      else if (!clkLossReq)
        lossCnt <= lossCnt + 12'h001;
    end
  end

  // Watchdog prescaler: one tick every twelve clocks
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wdPre <= 4'h0;
    else if (state == ST_HOLD || wdPre == 4'(`RSC_WD_PRESCALE - 1))
      wdPre <= 4'h0;
    else
      wdPre <= wdPre + 4'h1;
  end

  assign wdTick = (state == ST_RUN) && wdPre == 4'(`RSC_WD_PRESCALE - 1);

  // Watchdog counter; re-enabled by every reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdEn  <= 1'b1;
      wdCnt <= 8'h00;
    end
    else if (state == ST_HOLD)
    begin
      wdEn  <= 1'b1;
      wdCnt <= 8'h00;
    end
    else
    begin
      if (busWrite && regIdx == `RSC_IDX_WATCHDOG)
        wdEn <= wb_dat_i[`RSC_WD_ENABLE_BIT];
      if (watchdogKick || (busWrite && regIdx == `RSC_IDX_WATCHDOG
                           && wb_dat_i[`RSC_WD_KICK_BIT]))
        wdCnt <= 8'h00;
      else if (wdEn && wdTick && !wdReq)
        wdCnt <= wdCnt + 8'h01;
    end
  end

  // Read mux
  always_comb
  begin
    next_rdata = 8'h00;
    case (regIdx)
      `RSC_IDX_SUPPLY_CTL:
      begin
        next_rdata[`RSC_SM_ENABLE_BIT] = supplyMonitorOn;
        next_rdata[`RSC_SM_STATUS_BIT] = supplyAbove;
      end
      `RSC_IDX_CAUSE:
        next_rdata = {1'b0, flags};
      `RSC_IDX_WATCHDOG:
        next_rdata[`RSC_WD_ENABLE_BIT] = wdEn;
      default:
        next_rdata = 8'h00;
    endcase
  end

  // Wishbone slave: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busHit && !wb_ack_o;
      if (busHit && !wb_ack_o)
        wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // Checks
  property p_sw_force;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_RUN && swForce) |=> (state == ST_HOLD);
  endproperty
  a_sw_force: assert property (p_sw_force) else $error("software reset not taken");

  property p_sw_flag;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_HOLD && cause == C_SW ##1 state == ST_RUN) |-> flags.sw && !flags.pin;
  endproperty
  a_sw_flag: assert property (p_sw_flag) else $error("software flag wrong");

  property p_supply_gated;
    @(posedge mclk) disable iff (!rst_n)
    ($past(state) == ST_RUN && state == ST_HOLD && cause == C_SUPPLY)
      |-> $past(supplySrcEn && supplyMonitorOn);
  endproperty
  a_supply_gated: assert property (p_supply_gated) else $error("ungated supply reset");

  property p_pin_quiet;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_HOLD && cause != C_POR && cause != C_SUPPLY) |-> !extResetOe;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("internal reset drove pin");

  property p_low_bits_zero;
    @(posedge mclk) disable iff (!rst_n)
    (busHit && !wb_ack_o && regIdx == `RSC_IDX_SUPPLY_CTL) |=> wb_dat_o[5:0] == 6'h00;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("supply low bits set");

  property p_comp_reset;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_RUN && compEn && !comparatorOut) |=> state == ST_HOLD;
  endproperty
  a_comp_reset: assert property (p_comp_reset) else $error("comparator reset missed");

  property p_wd_after_reset;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_HOLD ##1 state == ST_RUN) |-> wdEn && wdCnt == 8'h00;
  endproperty
  a_wd_after_reset: assert property (p_wd_after_reset) else $error("watchdog not armed");

  property p_pin_flag;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_HOLD && cause == C_PIN ##1 state == ST_RUN) |-> flags == 7'h01;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag wrong");

  property p_loss_fire;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_RUN && clkLossEn && lossCnt == 12'(`RSC_CLKLOSS_CYCLES - 1)
     && systemClockSample == lastClkSample && !reqValid) |=> ##1 state == ST_HOLD;
  endproperty
  a_loss_fire: assert property (p_loss_fire) else $error("clock loss not detected");

  property p_mem_reset;
    @(posedge mclk) disable iff (!rst_n)
    (state == ST_RUN && reqValid && reqCause == C_MEM) |=> state == ST_HOLD && cause == C_MEM;
  endproperty
  a_mem_reset: assert property (p_mem_reset) else $error("memory error reset missed");

endmodule // reset_source_controller

// ### rtl/reset_source_consts.svh
// Offsets, field positions and timing counts of the reset source controller
`ifndef RESET_SOURCE_CONSTS_SVH
`define RESET_SOURCE_CONSTS_SVH

// Register indices; byte address is four times the index
`define RSC_IDX_SUPPLY_CTL   8'hff
`define RSC_IDX_CAUSE        8'hef
`define RSC_IDX_WATCHDOG     8'h10

// Supply monitor control fields
`define RSC_SM_ENABLE_BIT    7
`define RSC_SM_STATUS_BIT    6

// Reset cause register fields
`define RSC_PIN_BIT          0
`define RSC_POR_BIT          1
`define RSC_CLKLOSS_BIT      2
`define RSC_WDOG_BIT         3
`define RSC_SWRST_BIT        4
`define RSC_COMP_BIT         5
`define RSC_MEMORY_ERROR_FLAG_BIT       6

// Watchdog control fields
`define RSC_WD_ENABLE_BIT    0
`define RSC_WD_KICK_BIT      1

// Timing
`define RSC_MCLK_KHZ         20000
`define RSC_CLKLOSS_US       100
`define RSC_CLKLOSS_CYCLES   ((`RSC_CLKLOSS_US * `RSC_MCLK_KHZ) / 1000)
`define RSC_WD_PRESCALE      12
`define RSC_HOLD_CYCLES      4

`endif

// ### rtl/reset_source_pkg.sv
// Types shared by the reset source controller
package reset_source_pkg;

  typedef enum logic [0:0] {ST_RUN, ST_HOLD} rstState_t;

  typedef enum logic [2:0] {
    C_POR, C_SUPPLY, C_PIN, C_CLKLOSS, C_COMP, C_WDOG, C_MEM, C_SW
  } cause_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } codeAccess_t;

  typedef struct packed {
    logic memory_error_flag;
    logic comp;
    logic sw;
    logic wdog;
    logic clkLoss;
    logic por;
    logic pin;
  } causeFlags_t;

endpackage

// ### tb/ext_reset_driver.sv
// Model of the external reset circuit on the open-drain reset pin
module ext_reset_driver (
  input  wire logic       mclk,
  input  wire logic       pullStart,
  input  wire logic [7:0] pullCycles,
  input  wire logic       extResetOut,
  input  wire logic       extResetOe,
  output logic            pinLevel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  initial left = 8'h00;
  // Hold time is set per request; the test makes one pull, of twelve cycles
  always @(posedge mclk)
  begin
    if (pullStart)
      left <= pullCycles;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  // Pull-up wins only when nobody pulls the wire low
  assign pinLevel_n = (left != 8'h00 || (extResetOe && !extResetOut)) ? 1'b0 : 1'b1;
endmodule // ext_reset_driver

// ### tb/reset_source_controller_test.sv
// Self-checking testbench of the reset source controller
`include "reset_source_consts.svh"
module reset_source_controller_test
  import reset_source_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] LIMIT   = 16'h1fff;
  localparam logic [9:0]  A_SUP   = 10'h3fc;
  localparam logic [9:0]  A_CAUSE = 10'h3bc;
  localparam logic [9:0]  A_WD    = 10'h040;
  logic        mclk, rst_n, wbCyc, wbStb, wbWe, wbAck, extOut, extOe, pin_n, oeSeen;
  logic        supplyAbove, monOn, system_clock, clkRun, compOut, kick, sysReset_n, wdTick, pullGo;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic [7:0]  pullLen, rd;
  codeAccess_t code;
  int          n_errors, comparisons, lowCnt, preCnt;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (clkRun)
      system_clock <= ~system_clock;

  reset_source_controller #(.CODE_LIMIT(LIMIT), .WD_LIMIT(4)) reset_source_controller_inst (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .extResetIn_n(pin_n), .extResetOut(extOut), .extResetOe(extOe),
    .supplyAbove(supplyAbove), .supplyMonitorOn(monOn), .systemClockSample(system_clock),
    .comparatorOut(compOut), .watchdogKick(kick), .codeAccess(code),
    .sysReset_n(sysReset_n), .wdTick(wdTick));
  ext_reset_driver ext_reset_driver_inst (.mclk(mclk), .pullStart(pullGo),
    .pullCycles(pullLen), .extResetOut(extOut), .extResetOe(extOe), .pinLevel_n(pin_n));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic timeOut(input string what);
    n_errors++;
    $display("MISMATCH at %0t: timeout %s", $time, what);
    wrap_up();
  endtask

  // One classic cycle; read data is taken at the edge that samples ack high
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= 4'h1;
    wbDatW <= {24'h000000, d};
    do
    begin
      @(negedge mclk);
      n++;
      if (n > 20)
        timeOut("bus");
    end
    while (wbAck !== 1'b1);
    @(posedge mclk);
    rd = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic quiet(input int n);
    repeat (n) @(negedge mclk);
    check({7'h00, sysReset_n}, 8'h01, "stays out of reset");
  endtask

  // Waits out one reset, then parks the watchdog so later scenarios are not cut short
  task automatic waitReset;
    int n;
    preCnt = 0;
    while (sysReset_n !== 1'b0)
    begin
      @(negedge mclk);
      preCnt++;
      if (preCnt > 3000)
        timeOut("reset entry");
    end
    lowCnt = 0;
    oeSeen = 1'b0;
    while (sysReset_n !== 1'b1)
    begin
      oeSeen |= extOe;
      @(negedge mclk);
      lowCnt++;
      if (lowCnt > 200)
        timeOut("reset exit");
    end
    n = 0;
    while (wdTick !== 1'b1)
    begin
      @(negedge mclk);
      n++;
      if (n > 13)
        timeOut("watchdog tick");
    end
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (wdTick !== 1'b1 && n < 20);
    check(8'(n), 8'(`RSC_WD_PRESCALE), "tick spacing");
    bus(1'b1, A_WD, 8'h00);
  endtask

  task automatic flags(input logic [7:0] exp, input logic oe);
    check({7'h00, oeSeen}, {7'h00, oe}, "pin drive");
    bus(1'b0, A_CAUSE, 8'h00);
    check(rd, exp, "cause flags");
  endtask

  initial
  begin
    rst_n = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
    {system_clock, kick, pullGo, pullLen, code, n_errors, comparisons} = '0;
    {supplyAbove, clkRun, compOut} = 3'b111;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    waitReset();
    check({7'h00, monOn}, 8'h01, "monitor on");
    flags(8'h02, 1'b1);
    bus(1'b0, A_SUP, 8'h00);
    check(rd, 8'hc0, "supply control");
    bus(1'b0, 10'h004, 8'h00);
    check(rd, 8'h00, "unmapped read");
    bus(1'b1, A_SUP, 8'h3f);
    bus(1'b0, A_SUP, 8'h00);
    check(rd, 8'h40, "low bits");
    check({7'h00, monOn}, 8'h00, "monitor off");
    bus(1'b1, A_CAUSE, 8'h10);
    waitReset();
    check(8'(lowCnt), 8'(`RSC_HOLD_CYCLES), "software hold");
    flags(8'h10, 1'b0);
    bus(1'b0, A_SUP, 8'h00);
    check(rd, 8'h40, "monitor kept off");
    pullLen <= 8'h0c;
    pullGo <= 1'b1;
    @(posedge mclk);
    pullGo <= 1'b0;
    waitReset();
    check({7'h00, lowCnt >= 12}, 8'h01, "pin hold");
    flags(8'h01, 1'b0);
    compOut <= 1'b0;
    quiet(10);
    @(posedge mclk);
    compOut <= 1'b1;
    bus(1'b1, A_CAUSE, 8'h20);
    compOut <= 1'b0;
    repeat (2) @(posedge mclk);
    compOut <= 1'b1;
    waitReset();
    flags(8'h20, 1'b0);
    code <= '{1'b1, LIMIT};
    @(posedge mclk);
    code <= '0;
    quiet(6);
    @(posedge mclk);
    code <= '{1'b1, LIMIT + 16'h0001};
    @(posedge mclk);
    code <= '0;
    waitReset();
    flags(8'h40, 1'b0);
    bus(1'b1, A_WD, 8'h01);
    repeat (8)
    begin
      @(posedge mclk);
      kick <= 1'b1;
      @(posedge mclk);
      kick <= 1'b0;
      repeat (18) @(posedge mclk);
    end
    quiet(1);
    waitReset();
    flags(8'h08, 1'b0);
    bus(1'b1, A_CAUSE, 8'h04);
    clkRun <= 1'b0;
    waitReset();
    clkRun <= 1'b1;
    check({7'h00, preCnt > 1990 && preCnt < 2010}, 8'h01, "clock loss delay");
    flags(8'h04, 1'b0);
    bus(1'b1, A_CAUSE, 8'h00);
    clkRun <= 1'b0;
    quiet(2100);
    @(posedge mclk);
    clkRun <= 1'b1;
    bus(1'b1, A_SUP, 8'h80);
    supplyAbove <= 1'b0;
    quiet(10);
    bus(1'b0, A_SUP, 8'h00);
    check(rd, 8'h80, "status low");
    supplyAbove <= 1'b1;
    bus(1'b1, A_CAUSE, 8'h02);
    supplyAbove <= 1'b0;
    repeat (3) @(posedge mclk);
    supplyAbove <= 1'b1;
    waitReset();
    flags(8'h02, 1'b1);
    bus(1'b0, A_SUP, 8'h00);
    check(rd, 8'hc0, "monitor kept on");
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    timeOut("run");
  end
endmodule // reset_source_controller_test
